/* File: core/spim_core.sv */
// Purpose: SPI master chip select, serial clock and delay engine
// Assumes: Mode 0 serial timing, 100 MHz ref_clk_i, DMA writes the
//          transmit word over the same register port
// Notes:   Master side only; select, clock and delay timing
// Contract
// - serial clock edges come from clock divided by 1..255
// - divisor one gives an edge every peripheral clock
// - divisor resets to zero; software loads nonzero first
// - each chip select keeps its own divisor, applied per word
// - one shared delay between dropping a held select and asserting the next
// - per-select delay from select assert to first clock edge
// - per-select delay between consecutive words
// - all select lines high before transfers, and after them unless hold is set
// - fixed mode takes target from mode register only
// - variable mode takes target from each transmit word
// - transmit word: eob bit 24, select 19:16, data 15:0
// - disable releases select after last word, keeps setup
// - fixed mode DMA steps 1 byte for 8 bits, else 2
// - variable mode DMA steps 4 bytes per word
// - variable mode takes 32 bits, length from select config
// - DMA consumes transmit-empty and receive-full flags
// - decode mode drives the 4-bit select code directly
// - without decode only lowest zero select line goes low
// - idle code all ones on select lines between transfers
// - decoded codes 4n..4n+3 use configuration n
// - hold bit keeps select until other target, eob or disable
// - done flag rises after the last inter-word delay
module spim_core (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Serial link
  output logic serial_clock_o,
  output logic mosi_o,
  input wire logic miso_i,
  output logic [3:0] chip_select_lines_o,
  // DMA handshake
  output logic dma_tx_req_o,
  output logic dma_rx_req_o,
  output logic [2:0] dma_step_o
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic en;
    logic transmit_empty_flag;
    logic txe;
    logic receive_full_flag;
    logic eob_req;
    logic eob_word;
    logic full;
    logic [15:0] txd;
    logic [3:0] txpcs;
    logic txeob;
    logic ps;
    logic dec;
    logic [3:0] mpcs;
    logic [7:0] scd;
    logic [3:0][31:0] cfg;
    spim_pkg::spim_st_t st;
    logic [7:0] cnt;
    logic [4:0] bitcnt;
    logic [15:0] sh;
    logic [15:0] rx;
    logic [15:0] rdr;
    logic [1:0] cap;
    logic [1:0] capl;
    logic [3:0] cs;
    logic [3:0] tl;
    logic [1:0] cidx;
    logic serial_clock;
    logic mosi;
    logic m1;
    logic m2;
    logic [31:0] rdata;
    logic dreq_tx;
    logic dreq_rx;
    logic [2:0] step;
  } spim_state_t;

  spim_state_t r_ff;
  spim_state_t nxt_r;

  // Lowest select line that is low, used without decoding
  function automatic logic [1:0] low_idx(input logic [3:0] p);
    logic [1:0] k;
    k = 2'h3;
    for (int i = 3; i >= 0; i--) begin
      if (!p[i]) begin
        k = i[1:0];
      end
    end
    return k;
  endfunction

  // Word length from a configuration word, clamped to 8..16
  function automatic logic [4:0] cfg_bits(input logic [31:0] c);
    logic [3:0] f;
    f = c[spim_pkg::CFG_BITS_LO +: 4];
    if (f > spim_pkg::BITS_MAXCODE) begin
      return spim_pkg::BITS_MAX;
    end
    return spim_pkg::BITS_BASE + {1'b0, f};
  endfunction

  // ************************************************************
  // Target selection
  // ************************************************************
  logic [3:0] tgt_pcs;
  logic [1:0] tgt_idx;
  logic [3:0] tgt_lines;
  logic [31:0] tgt_cfg;
  logic [31:0] act_cfg;
  logic [7:0] act_div;
  logic tick;
  logic hold;

  // Variable mode uses the word's own field, else the mode register
  assign tgt_pcs = r_ff.ps ? r_ff.txpcs : r_ff.mpcs;
  // Decoded codes share configuration per group of four
  assign tgt_idx = r_ff.dec ? tgt_pcs[3:2] : low_idx(tgt_pcs);
  assign tgt_cfg = r_ff.cfg[tgt_idx];
  assign act_cfg = r_ff.cfg[r_ff.cidx];
  assign act_div = act_cfg[spim_pkg::CFG_DIV_LO +: 8];
  assign hold = act_cfg[spim_pkg::CFG_HOLD];

  // Without decoding one line low at most; all-ones code never selects anything
  always_comb begin
    tgt_lines = spim_pkg::CS_IDLE;
    if (r_ff.dec) begin
      tgt_lines = tgt_pcs;
    end else if (tgt_pcs != spim_pkg::CS_IDLE) begin
      tgt_lines[tgt_idx] = 1'b0;
    end
  end

  // Clock-edge enable: divisor zero is undefined, runs as one
  assign tick = ({1'b0, r_ff.cnt} + 9'h001) >= {1'b0, act_div};

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    nxt_r = r_ff;
    nxt_r.rdata = 32'h0000_0000;
    // Two-stage synchroniser on the incoming data pin
    nxt_r.m1 = miso_i;
    nxt_r.m2 = r_ff.m1;

    // Reading the receive word clears its flag; hardware set wins
    if (reg_rd_i && reg_addr_i == spim_pkg::OFF_RXWORD) begin
      nxt_r.receive_full_flag = 1'b0;
    end

    // Capture two cycles after each rising edge: the synchroniser
    // delays the pin by two, so even at divisor one the bit at the edge is taken
    nxt_r.cap = {r_ff.cap[0], 1'b0};
    nxt_r.capl = {r_ff.capl[0], 1'b0};
    if (r_ff.cap[1]) begin
      nxt_r.rx = {r_ff.rx[14:0], r_ff.m2};
    end
    if (r_ff.capl[1]) begin
      // Last bit in: word moves on, set wins over a read clear
      nxt_r.rdr = {r_ff.rx[14:0], r_ff.m2};
      nxt_r.receive_full_flag = 1'b1;
    end

    unique case (r_ff.st)
      spim_pkg::ST_IDLE: begin
        if (r_ff.en && r_ff.full) begin
          // Word leaves the holding register: empty flag rises
          nxt_r.full = 1'b0;
          nxt_r.transmit_empty_flag = 1'b1;
          nxt_r.txe = 1'b0;
          nxt_r.sh = r_ff.txd;
          // Upper bits of a short word read back as zero
          nxt_r.rx = 16'h0000;
          nxt_r.eob_word = r_ff.ps & r_ff.txeob;
          nxt_r.cidx = tgt_idx;
          nxt_r.tl = tgt_lines;
          nxt_r.bitcnt = cfg_bits(tgt_cfg);
          if (r_ff.cs == tgt_lines &&
              !tgt_cfg[spim_pkg::CFG_RELEASE]) begin
            // Same slave still held: straight into shifting
            nxt_r.st = spim_pkg::ST_SHIFT;
            nxt_r.cnt = 8'h00;
            nxt_r.mosi = r_ff.txd[4'(cfg_bits(tgt_cfg) - 5'h01)];
          end else if (r_ff.cs == spim_pkg::CS_IDLE) begin
            nxt_r.cs = tgt_lines;
            nxt_r.st = spim_pkg::ST_SETUP;
            nxt_r.cnt = tgt_cfg[spim_pkg::CFG_STC_LO +: 8];
          end else begin
            // Other slave or forced release: drop, then wait
            nxt_r.cs = spim_pkg::CS_IDLE;
            nxt_r.st = spim_pkg::ST_SELGAP;
            nxt_r.cnt = r_ff.scd;
          end
        end else if (r_ff.eob_req || !r_ff.en) begin
          // Held select ends on command or disable
          nxt_r.cs = spim_pkg::CS_IDLE;
          nxt_r.eob_req = 1'b0;
        end
      end
      spim_pkg::ST_SELGAP: begin
        if (r_ff.cnt == 8'h00) begin
          nxt_r.cs = r_ff.tl;
          nxt_r.st = spim_pkg::ST_SETUP;
          nxt_r.cnt = act_cfg[spim_pkg::CFG_STC_LO +: 8];
        end else begin
          nxt_r.cnt = r_ff.cnt - 8'h01;
        end
      end
      spim_pkg::ST_SETUP: begin
        if (r_ff.cnt == 8'h00) begin
          nxt_r.st = spim_pkg::ST_SHIFT;
          nxt_r.serial_clock = 1'b0;
          nxt_r.mosi = r_ff.sh[4'(r_ff.bitcnt - 5'h01)];
        end else begin
          nxt_r.cnt = r_ff.cnt - 8'h01;
        end
      end
      spim_pkg::ST_SHIFT: begin
        if (!tick) begin
          nxt_r.cnt = r_ff.cnt + 8'h01;
        end else begin
          // Divisor of one makes every cycle a clock edge
          nxt_r.cnt = 8'h00;
          nxt_r.serial_clock = !r_ff.serial_clock;
          if (!r_ff.serial_clock) begin
            // Rising edge: slave bit is taken once synchronised
            nxt_r.cap[0] = 1'b1;
            nxt_r.capl[0] = r_ff.bitcnt == 5'h01;
          end else if (r_ff.bitcnt == 5'h01) begin
            nxt_r.st = spim_pkg::ST_XFGAP;
            nxt_r.cnt = act_cfg[spim_pkg::CFG_ITD_LO +: 8];
          end else begin
            // Falling edge shifts the next bit out
            nxt_r.bitcnt = r_ff.bitcnt - 5'h01;
            nxt_r.mosi = r_ff.sh[4'(r_ff.bitcnt - 5'h02)];
          end
        end
      end
      spim_pkg::ST_XFGAP: begin
        if (r_ff.cnt != 8'h00) begin
          nxt_r.cnt = r_ff.cnt - 8'h01;
        end else begin
          nxt_r.st = spim_pkg::ST_IDLE;
          if (!(r_ff.full && r_ff.en)) begin
            // Done only once the trailing delay has run out
            nxt_r.txe = 1'b1;
            if (!hold) begin
              nxt_r.cs = spim_pkg::CS_IDLE;
            end
          end
          if (r_ff.eob_word || r_ff.eob_req) begin
            nxt_r.cs = spim_pkg::CS_IDLE;
            nxt_r.eob_req = 1'b0;
            nxt_r.eob_word = 1'b0;
          end
        end
      end
      default: begin
        nxt_r.st = spim_pkg::ST_IDLE;
        nxt_r.cs = spim_pkg::CS_IDLE;
      end
    endcase

    // Register writes after the sequencer so commands take effect
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        spim_pkg::OFF_CONTROL: begin
          if (reg_wdata_i[spim_pkg::CTL_ENABLE]) begin
            nxt_r.en = 1'b1;
            nxt_r.transmit_empty_flag = !r_ff.full;
            nxt_r.txe = r_ff.st == spim_pkg::ST_IDLE;
          end
          if (reg_wdata_i[spim_pkg::CTL_DISABLE]) begin
            nxt_r.en = 1'b0;
          end
          if (reg_wdata_i[spim_pkg::CTL_EOB]) begin
            nxt_r.eob_req = 1'b1;
          end
        end
        spim_pkg::OFF_MODE: begin
          nxt_r.ps = reg_wdata_i[spim_pkg::MODE_SELMODE];
          nxt_r.dec = reg_wdata_i[spim_pkg::MODE_DECODE];
          nxt_r.mpcs = reg_wdata_i[spim_pkg::MODE_PCS_LO +: 4];
          nxt_r.scd = reg_wdata_i[spim_pkg::MODE_SCD_LO +: 8];
        end
        spim_pkg::OFF_TXWORD: begin
          // Full 32-bit word: data low, select and eob high
          nxt_r.txd = reg_wdata_i[15:0];
          nxt_r.txpcs = reg_wdata_i[spim_pkg::TXW_PCS_LO +: 4];
          nxt_r.txeob = reg_wdata_i[spim_pkg::TXW_EOB];
          nxt_r.full = 1'b1;
          nxt_r.transmit_empty_flag = 1'b0;
          nxt_r.txe = 1'b0;
          // Pointer step tells the DMA how wide the buffer word is
          if (r_ff.ps) begin
            nxt_r.step = spim_pkg::STEP_WORD;
          end else if (cfg_bits(r_ff.cfg[tgt_idx])
                       == spim_pkg::BITS_BASE) begin
            nxt_r.step = spim_pkg::STEP_BYTE;
          end else begin
            nxt_r.step = spim_pkg::STEP_HALF;
          end
        end
        default: begin
        end
      endcase
    end

    // Per-select configuration words
    for (int i = 0; i < 4; i++) begin
      if (reg_wr_i && reg_addr_i ==
          spim_pkg::OFF_CSCFG0 + 8'(i) * spim_pkg::CSCFG_STEP) begin
        nxt_r.cfg[i] = reg_wdata_i;
      end
    end

    // Read data stands for the one cycle after the strobe
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        spim_pkg::OFF_MODE: begin
          nxt_r.rdata[spim_pkg::MODE_SELMODE] = r_ff.ps;
          nxt_r.rdata[spim_pkg::MODE_DECODE] = r_ff.dec;
          nxt_r.rdata[spim_pkg::MODE_PCS_LO +: 4] = r_ff.mpcs;
          nxt_r.rdata[spim_pkg::MODE_SCD_LO +: 8] = r_ff.scd;
        end
        spim_pkg::OFF_RXWORD: begin
          nxt_r.rdata[15:0] = r_ff.rdr;
        end
        spim_pkg::OFF_STATUS: begin
          nxt_r.rdata[spim_pkg::STAT_RXFULL] = r_ff.receive_full_flag;
          nxt_r.rdata[spim_pkg::STAT_TRANSMITTER_EMPTY_FLAG] = r_ff.transmit_empty_flag;
          nxt_r.rdata[spim_pkg::STAT_TXDONE] = r_ff.txe;
          nxt_r.rdata[spim_pkg::STAT_ENABLED] = r_ff.en;
        end
        default: begin
        end
      endcase
      for (int i = 0; i < 4; i++) begin
        if (reg_addr_i ==
            spim_pkg::OFF_CSCFG0 + 8'(i) * spim_pkg::CSCFG_STEP) begin
          nxt_r.rdata = r_ff.cfg[i];
        end
      end
    end

    // Flags feed the DMA handshake as well as the status register
    nxt_r.dreq_tx = nxt_r.en & nxt_r.transmit_empty_flag;
    nxt_r.dreq_rx = nxt_r.receive_full_flag;
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_ff <= '0;
      r_ff.cs <= spim_pkg::CS_IDLE;
      r_ff.cfg <= {4{spim_pkg::CSCFG_RESET}};
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata_o = r_ff.rdata;
  assign serial_clock_o = r_ff.serial_clock;
  assign mosi_o = r_ff.mosi;
  assign chip_select_lines_o = r_ff.cs;
  assign dma_tx_req_o = r_ff.dreq_tx;
  assign dma_rx_req_o = r_ff.dreq_rx;
  assign dma_step_o = r_ff.step;

endmodule

/* File: include/spim_pkg.sv */
// Purpose: Constants and types for the SPI master select/timing core
// Assumes: 32-bit register port, 8-bit byte address
// Notes:   Offsets are byte addresses, one aligned word per register
package spim_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_RXWORD = 8'h08;
  localparam logic [7:0] OFF_TXWORD = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_CSCFG0 = 8'h30;
  localparam logic [7:0] CSCFG_STEP = 8'h04;

  // ************************************************************
  // Field positions
  // ************************************************************
  // Control register (write-only commands)
  localparam int CTL_ENABLE = 0;
  localparam int CTL_DISABLE = 1;
  localparam int CTL_EOB = 24;
  // Mode register
  localparam int MODE_SELMODE = 1;
  localparam int MODE_DECODE = 2;
  localparam int MODE_PCS_LO = 16;
  localparam int MODE_SCD_LO = 24;
  // Transmit word
  localparam int TXW_PCS_LO = 16;
  localparam int TXW_EOB = 24;
  // Chip select configuration
  localparam int CFG_RELEASE = 2;
  localparam int CFG_HOLD = 3;
  localparam int CFG_BITS_LO = 4;
  localparam int CFG_DIV_LO = 8;
  localparam int CFG_STC_LO = 16;
  localparam int CFG_ITD_LO = 24;
  // Status register
  localparam int STAT_RXFULL = 0;
  localparam int STAT_TRANSMITTER_EMPTY_FLAG = 1;
  localparam int STAT_TXDONE = 9;
  localparam int STAT_ENABLED = 16;

  // ************************************************************
  // Values
  // ************************************************************
  localparam logic [3:0] CS_IDLE = 4'hf;
  localparam logic [3:0] BITS_MAXCODE = 4'h8;
  localparam logic [4:0] BITS_BASE = 5'h08;
  localparam logic [4:0] BITS_MAX = 5'h10;
  localparam logic [2:0] STEP_BYTE = 3'h1;
  localparam logic [2:0] STEP_HALF = 3'h2;
  localparam logic [2:0] STEP_WORD = 3'h4;
  localparam logic [31:0] CSCFG_RESET = 32'h0000_0000;

  // Transfer sequencer, Gray along idle->gap->setup->shift->gap
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SELGAP = 3'b001,
    ST_SETUP = 3'b011,
    ST_SHIFT = 3'b010,
    ST_XFGAP = 3'b110
  } spim_st_t;

endpackage

/* File: test/spim_core_monitor.sv */
// Purpose: Port checks for the select and timing core
// Assumes: Setup is mirrored from register writes seen at the port
// Notes:   Setup registers are changed only while the link is idle
module spim_core_monitor (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // Serial link
  input wire logic serial_clock_o,
  input wire logic mosi_o,
  input wire logic [3:0] chip_select_lines_o,
  // DMA step
  input wire logic [2:0] dma_step_o
);
  // ********
  // Mirror
  // ********
  logic [31:0] mode_ff;
  logic [31:0] cfg_ff [4];
  logic [7:0] hi_ff;
  logic dec;
  logic [31:0] cur_cfg;
  logic [31:0] tgt_cfg;
  logic [7:0] div_exp;
  logic [2:0] step_exp;

  function automatic logic [1:0] cfg_idx(input logic [3:0] c, input logic d);
    if (d) return c[3:2];
    casez (c)
      4'b???0: return 2'h0;
      4'b??01: return 2'h1;
      4'b?011: return 2'h2;
      default: return 2'h3;
    endcase
  endfunction

  function automatic logic [3:0] cs_code(input logic [3:0] p, input logic d);
    if (d) return p;
    casez (p)
      4'b???0: return 4'he;
      4'b??01: return 4'hd;
      4'b?011: return 4'hb;
      4'b0111: return 4'h7;
      default: return 4'hf;
    endcase
  endfunction

  // Config in use follows the asserted line, not the last write
  assign dec = mode_ff[spim_pkg::MODE_DECODE];
  assign cur_cfg = cfg_ff[cfg_idx(chip_select_lines_o, dec)];
  assign tgt_cfg = cfg_ff[cfg_idx(cs_code(mode_ff[19:16], dec), dec)];
  assign div_exp = (cur_cfg[15:8] == 8'h00) ? 8'h01 : cur_cfg[15:8];
  assign step_exp = mode_ff[spim_pkg::MODE_SELMODE] ? spim_pkg::STEP_WORD :
      (tgt_cfg[7:4] == 4'h0) ? spim_pkg::STEP_BYTE : spim_pkg::STEP_HALF;

  // Setup mirror and high-phase counter
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_ff <= '0;
      cfg_ff <= '{default: '0};
      hi_ff <= '0;
    end else begin
      if (reg_wr_i && reg_addr_i == spim_pkg::OFF_MODE) mode_ff <= reg_wdata_i;
      for (int i = 0; i < 4; i++) begin
        if (reg_wr_i && reg_addr_i == spim_pkg::OFF_CSCFG0 + 8'(4 * i))
          cfg_ff[i] <= reg_wdata_i;
      end
      hi_ff <= serial_clock_o ? hi_ff + 8'h01 : 8'h00;
    end
  end

  // ********
  // Checks
  // ********
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_tx_write;
    reg_wr_i && reg_addr_i == spim_pkg::OFF_TXWORD;
  endsequence
  sequence s_high_end;
    $fell(serial_clock_o) && chip_select_lines_o != spim_pkg::CS_IDLE;
  endsequence

  property p_reset_idle;
    $rose(rst_n_i) |-> chip_select_lines_o == 4'hf && !serial_clock_o;
  endproperty
  property p_one_line;
    !dec |-> chip_select_lines_o inside {4'hf, 4'he, 4'hd, 4'hb, 4'h7};
  endproperty
  property p_fixed_target;
    !mode_ff[spim_pkg::MODE_SELMODE] && chip_select_lines_o != 4'hf
      |-> chip_select_lines_o == cs_code(mode_ff[19:16], dec);
  endproperty
  property p_half_period;
    s_high_end |-> hi_ff == div_exp;
  endproperty
  property p_cs_steady;
    serial_clock_o |-> $stable(chip_select_lines_o);
  endproperty
  property p_mosi_steady;
    serial_clock_o |-> $stable(mosi_o);
  endproperty
  property p_step;
    s_tx_write |=> dma_step_o == $past(step_exp);
  endproperty
  property p_rdata_gap;
    !$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000;
  endproperty

  a_reset_idle: assert property (p_reset_idle)
    else $error("selects not idle after reset");
  a_one_line: assert property (p_one_line)
    else $error("more than one select low");
  a_fixed_target: assert property (p_fixed_target)
    else $error("wrong select in fixed mode");
  a_half_period: assert property (p_half_period)
    else $error("serial clock high phase wrong");
  a_cs_steady: assert property (p_cs_steady)
    else $error("select moved during clock high");
  a_mosi_steady: assert property (p_mosi_steady)
    else $error("data moved during clock high");
  a_step: assert property (p_step)
    else $error("dma step wrong");
  a_rdata_gap: assert property (p_rdata_gap)
    else $error("read data outside its cycle");
endmodule

/* File: test/spim_core_tb_top.sv */
// Purpose: Register-driven scenarios for the select and timing core
// Assumes: Transfers run to completion before setup is changed
// Notes:   Waits poll the status done bit under a fixed bound
module spim_core_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_i;
  logic rst_n_i;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr_s;
  logic rd_s;
  logic [31:0] rdata;
  logic sclk;
  logic mosi;
  logic miso;
  logic [3:0] cs;
  logic [15:0] rx;
  logic [3:0] seen;
  logic [31:0] d;
  logic dreq_tx;
  logic dreq_rx;
  int fail_count = 0;
  int n_compared = 0;

  spim_core u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s),
    .reg_rd_i(rd_s), .reg_rdata_o(rdata), .serial_clock_o(sclk),
    .mosi_o(mosi), .miso_i(miso), .chip_select_lines_o(cs),
    .dma_tx_req_o(dreq_tx), .dma_rx_req_o(dreq_rx), .dma_step_o());
  spim_slave_model u_slave (.serial_clock_i(sclk), .mosi_i(mosi),
    .chip_select_lines_i(cs), .miso_o(miso), .rx_o(rx), .cs_seen_o(seen));

  // ********
  // Tasks
  // ********
  task automatic complete_run();
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge ref_clk_i);
    wr_s <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge ref_clk_i);
    rd_s <= 1'b0;
    @(negedge ref_clk_i);
    v = rdata;
  endtask
  task automatic done();
    logic [31:0] s;
    s = '0;
    repeat (3) @(posedge ref_clk_i);
    for (int i = 0; i < 400 && s[9] !== 1'b1; i++) rd(8'h10, s);
    if (s[9] !== 1'b1) begin
      fail_count++;
      complete_run();
    end
  endtask
  // Cycles to first clock (gap=0) or cycles of released selects (gap=1)
  task automatic span(input bit gap, input int e);
    int n;
    n = 0;
    while (((cs == 4'hf) != gap) && n < 400) begin
      @(negedge ref_clk_i);
      n++;
    end
    n = 0;
    while ((gap ? cs == 4'hf : !sclk) && n < 400) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk(32'(n), 32'(e));
  endtask

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    rst_n_i = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr_s = 1'b0;
    rd_s = 1'b0;
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rd(8'h30, d);
    chk(d, 32'h0000_0000);
    rd(8'h80, d);
    chk(d, 32'h0000_0000);
    wr(8'h30, 32'h0000_0100);
    wr(8'h34, 32'h0102_0380);
    wr(8'h04, 32'h020e_0000);
    wr(8'h00, 32'h0000_0001);
    // Fixed mode: select field in the word is ignored
    wr(8'h0c, 32'h000d_00a5);
    done();
    chk(32'(rx[7:0]), 32'h0000_00a5);
    chk(32'(seen), 32'h0000_000e);
    chk(32'(cs), 32'h0000_000f);
    chk(32'(dreq_rx), 32'h0000_0001);
    rd(8'h08, d);
    chk(d, 32'h0000_00c3);
    chk(32'(dreq_rx), 32'h0000_0000);
    // Variable mode, per-word target and 16-bit config
    wr(8'h04, 32'h020e_0002);
    wr(8'h0c, 32'h000d_1234);
    span(1'b0, 6);
    done();
    chk(32'(rx), 32'h0000_1234);
    chk(32'(seen), 32'h0000_000d);
    rd(8'h08, d);
    chk(d, 32'h0000_c3a6);
    wr(8'h0c, 32'h0000_0055);
    done();
    chk(32'(seen), 32'h0000_000e);
    // Decoded code 5 runs on config one
    wr(8'h04, 32'h0205_0004);
    wr(8'h0c, 32'h0000_beef);
    span(1'b0, 6);
    done();
    chk(32'(seen), 32'h0000_0005);
    chk(32'(rx), 32'h0000_beef);
    // Held select, then a change of target
    wr(8'h04, 32'h020e_0000);
    wr(8'h30, 32'h0000_0108);
    wr(8'h0c, 32'h0000_003c);
    done();
    chk(32'(cs), 32'h0000_000e);
    wr(8'h04, 32'h020e_0002);
    wr(8'h0c, 32'h000d_0077);
    span(1'b1, 3);
    done();
    chk(32'(cs), 32'h0000_000f);
    // End of burst given after the last word
    wr(8'h04, 32'h020e_0000);
    wr(8'h0c, 32'h0000_005a);
    wr(8'h00, 32'h0100_0000);
    done();
    chk(32'(cs), 32'h0000_000f);
    // Disable keeps setup; enable raises the empty flags
    wr(8'h00, 32'h0000_0002);
    rd(8'h10, d);
    chk(32'(d[16]), 32'h0000_0000);
    chk(32'(dreq_tx), 32'h0000_0000);
    rd(8'h34, d);
    chk(d, 32'h0102_0380);
    wr(8'h00, 32'h0000_0001);
    rd(8'h10, d);
    chk(d & 32'h0001_0202, 32'h0001_0202);
    chk(32'(dreq_tx), 32'h0000_0001);
    complete_run();
  end
endmodule

bind spim_core spim_core_monitor u_mon (.ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .serial_clock_o(serial_clock_o), .mosi_o(mosi_o),
  .chip_select_lines_o(chip_select_lines_o), .dma_step_o(dma_step_o));

/* File: test/spim_slave_model.sv */
// Purpose: Mode 0 serial slave facing the core
// Assumes: Any select code other than all ones selects this slave
// Notes:   Deselected reply line shows the inverse of its last bit
module spim_slave_model (
  // Link from the master
  input wire logic serial_clock_i,
  input wire logic mosi_i,
  input wire logic [3:0] chip_select_lines_i,
  // Reply and observations
  output logic miso_o,
  output logic [15:0] rx_o,
  output logic [3:0] cs_seen_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] tx_q = 16'hc3a6;
  logic [3:0] prev_cs = 4'hf;
  logic sel;

  assign sel = chip_select_lines_i != 4'hf;
  assign miso_o = sel ? tx_q[15] : ~tx_q[15];
  // Fresh reply word on every new selection
  always @(chip_select_lines_i) begin
    if (prev_cs == 4'hf) tx_q = 16'hc3a6;
    prev_cs = chip_select_lines_i;
  end
  // Capture on rising, shift reply on falling
  always @(posedge serial_clock_i) begin
    if (sel) begin
      rx_o <= {rx_o[14:0], mosi_i};
      cs_seen_o <= chip_select_lines_i;
    end
  end
  always @(negedge serial_clock_i) begin
    if (sel) tx_q <= {tx_q[14:0], ~tx_q[15]};
  end
endmodule
